//--- core/asa_pkg.sv
package asa_pkg;
	// register select codes
	localparam logic [1:0] ASA_RS_DATA = 2'h0;
	localparam logic [1:0] ASA_RS_STATUS = 2'h1;
	localparam logic [1:0] ASA_RS_CMD = 2'h2;
	localparam logic [1:0] ASA_RS_CTRL = 2'h3;
	// values after hardware reset
	localparam logic [7:0] ASA_CMD_RST = 8'h00;
	localparam logic [7:0] ASA_CTRL_RST = 8'h00;
	// command field positions
	localparam int ASA_CMD_DTR = 0;
	localparam int ASA_CMD_IRD = 1;
	localparam int ASA_CMD_TIC = 2;
	localparam int ASA_CMD_REM = 4;
	localparam int ASA_CMD_PME = 5;
	localparam int ASA_CMD_PMC = 6;
	// control field positions
	localparam int ASA_CTRL_RCS = 4;
	localparam int ASA_CTRL_WL = 5;
	localparam int ASA_CTRL_SBN = 7;
	// bit timing in 16x ticks
	localparam logic [4:0] ASA_TICKS_BIT = 5'h10;
	localparam logic [4:0] ASA_TICKS_HALF = 5'h08;
	localparam logic [4:0] ASA_TICKS_STOP15 = 5'h18;
	// baud generator
	localparam int ASA_XTAL_HZ = 1843200;
	localparam int ASA_OVERSAMPLE = 16;
	localparam int ASA_X16 = ASA_XTAL_HZ / ASA_OVERSAMPLE;
	localparam logic [15:0][11:0] ASA_BAUD_DIV = {
		12'(ASA_X16 / 19200), 12'(ASA_X16 / 9600), 12'(ASA_X16 / 7200), 12'(ASA_X16 / 4800),
		12'(ASA_X16 / 3600), 12'(ASA_X16 / 2400), 12'(ASA_X16 / 1800), 12'(ASA_X16 / 1200),
		12'(ASA_X16 / 600), 12'(ASA_X16 / 300), 12'(ASA_X16 / 150), 12'(ASA_X16 * 100 / 13458),
		12'(ASA_X16 * 100 / 10992), 12'(ASA_X16 / 75), 12'(ASA_X16 / 50), 12'h001};
	// receive buffer
	localparam int ASA_FIFO_DEPTH = 16;
	localparam int ASA_RX_W = 10;

	typedef enum logic [1:0] {
		ASA_TX_IDLE = 2'b01,
		ASA_TX_RUN = 2'b10
	} asa_tx_e;

	typedef enum logic [2:0] {
		ASA_RX_IDLE = 3'b001,
		ASA_RX_START = 3'b010,
		ASA_RX_BITS = 3'b100
	} asa_rx_e;

	typedef struct packed {
		logic select_high;
		logic select_low_n;
		logic reg_select_hi;
		logic reg_select_lo;
		logic rw;
		logic phi2;
		logic [7:0] data;
	} asa_bus_in_s;

	typedef struct packed {
		logic rxd;
		logic cts_n;
		logic dsr_n;
		logic carrier_detect_n;
		logic receive_clock_pin;
		logic crystal_in;
	} asa_modem_in_s;
endpackage

//--- core/asa_top.sv
`timescale 1ns/10ps
module asa_fifo #(
	parameter int W = 10,
	parameter int D = 16
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} asa_fifo_s;
	asa_fifo_s s_r;
	asa_fifo_s s_nxt;
	logic push;
	logic pop;

	assign in_ready = s_r.cnt != (AW + 1)'(D);
	assign out_valid = s_r.cnt != '0;
	assign out_data = s_r.mem[s_r.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
		s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule

// Behaviour
// - hardware reset clears command and control registers to all zeros.
// - hardware reset clears status except pin-following bits; transmit-empty set.
// - bus transfers complete at the falling edge of phase two while selected.
// - selected when first select high and second select low; register selects address.
// - direction high reads from device, low writes into device.
// - select 00 data, 01 soft reset or status, 10 command, 11 control.
// - soft reset clears command bits 4..0 and overrun, keeps control.
// - only command and control read back; transmit write-only, receive read-only.
// - interrupt line is open drain, pulled low while interrupt pending.
// - data lines float except during selected read cycles.
// - transmit NRZ, bit 0 first, bits above word length ignored.
// - first received bit lands in bit 0, upper bits zero, parity stripped.
// - receive clock pin is input, or 16x output when baud generator clocks receiver.
// - transmitter runs only while clear-to-send is low.
// - terminal-ready output is low when command bit 0 is set.
// - enabled interrupt condition sets status bit 7 and its flag, pulls line low.
// - status layout irq, set-ready, carrier, tx empty, rx full, overrun, framing, parity.
// - transmit rate is one of fifteen internal rates or external clock / 16.
// - receive rate is transmit rate or external receive clock / 16.
// - word length 5..8, even/odd/no parity, 1, 1.5 or 2 stop bits.
// - receive-full sets on transfer into receive register, clears on its read.
// - transmit-empty sets on move into shifter, clears on transmit write.
// - status read clears interrupt summary bit.
// - error bits raise no interrupt and clear after receive register read.
module asa_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// processor bus
	input wire logic hw_reset_n,
	input wire asa_pkg::asa_bus_in_s bus_in,
	output logic [7:0] data_out,
	output logic data_oe_n,
	output logic irq_out,
	output logic irq_oe_n,
	// modem side
	input wire asa_pkg::asa_modem_in_s modem_in,
	output logic txd,
	output logic rts_n,
	output logic dtr_n,
	output logic receive_clock_out,
	output logic receive_clock_oe_n,
	output logic crystal_out
);
	import asa_pkg::*;

	typedef struct packed {
		asa_bus_in_s bus_s1;
		asa_bus_in_s bus_s2;
		asa_modem_in_s mod_s1;
		asa_modem_in_s mod_s2;
		logic hrst_s1;
		logic hrst_s2;
		logic phi2_d;
		logic rxc_d;
		logic xtal_d;
		logic dsr_d;
		logic dcd_d;
		logic [7:0] cmd;
		logic [7:0] ctrl;
		logic [7:0] transmit_data;
		logic [7:0] receive_data;
		logic rx_reg_full;
		logic tx_reg_empty;
		logic overrun_flag;
		logic fe;
		logic pe;
		logic irq;
		logic [11:0] baud_cnt;
		asa_tx_e tx_st;
		logic [4:0] tx_tick;
		logic [3:0] tx_bit;
		logic [3:0] tx_nbits;
		logic [11:0] tx_sh;
		logic txd;
		asa_rx_e rx_st;
		logic [4:0] rx_tick;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_par;
		logic rx_push;
		logic [ASA_RX_W-1:0] rx_word;
		logic [7:0] dout;
		logic oe_n;
		logic rxc_o;
		logic rxc_oe_n;
		logic xo;
	} asa_state_s;

	asa_state_s s_r;
	asa_state_s s_nxt;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [ASA_RX_W-1:0] fifo_out_data;

	assign fifo_out_ready = ~s_r.rx_reg_full;

	asa_fifo #(
		.W(ASA_RX_W),
		.D(ASA_FIFO_DEPTH)
	) u_rx_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(s_r.rx_push),
		.in_ready(fifo_in_ready),
		.in_data(s_r.rx_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	always_comb begin
		asa_bus_in_s b;
		asa_modem_in_s m;
		logic sel, acc, wr, rd, tick16, rx_tick, tx_en, rx_ie, tx_ie;
		logic par, two_stop, half_stop, pme, last;
		logic [1:0] rs;
		logic [11:0] div;
		logic [3:0] wl;
		logic [7:0] masked;
		logic [7:0] status;
		logic [11:0] fr;
		logic [4:0] len;
		b = s_r.bus_s2;
		m = s_r.mod_s2;
		sel = 1'b0;
		acc = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		tick16 = 1'b0;
		rx_tick = 1'b0;
		tx_en = 1'b0;
		rx_ie = 1'b0;
		tx_ie = 1'b0;
		par = 1'b0;
		two_stop = 1'b0;
		half_stop = 1'b0;
		pme = 1'b0;
		last = 1'b0;
		rs = 2'h0;
		div = 12'h000;
		wl = 4'h0;
		masked = 8'h00;
		status = 8'h00;
		fr = 12'hFFF;
		len = ASA_TICKS_BIT;
		s_nxt = s_r;

		// two-stage synchronisers for every pin
		s_nxt.bus_s1 = bus_in;
		s_nxt.bus_s2 = s_r.bus_s1;
		s_nxt.mod_s1 = modem_in;
		s_nxt.mod_s2 = s_r.mod_s1;
		s_nxt.hrst_s1 = hw_reset_n;
		s_nxt.hrst_s2 = s_r.hrst_s1;
		s_nxt.phi2_d = b.phi2;
		s_nxt.rxc_d = m.receive_clock_pin;
		s_nxt.xtal_d = m.crystal_in;
		s_nxt.dsr_d = m.dsr_n;
		s_nxt.dcd_d = m.carrier_detect_n;
		s_nxt.xo = ~m.crystal_in;

		// bus decode; an access completes at the falling edge of phase two
		sel = b.select_high & ~b.select_low_n;
		rs = {b.reg_select_hi, b.reg_select_lo};
		acc = sel & s_r.phi2_d & ~b.phi2;
		wr = acc & ~b.rw;
		rd = acc & b.rw;
		status = {s_r.irq, m.dsr_n, m.carrier_detect_n, s_r.tx_reg_empty, s_r.rx_reg_full, s_r.overrun_flag, s_r.fe, s_r.pe};
		unique case (rs)
			ASA_RS_DATA: s_nxt.dout = s_r.receive_data;
			ASA_RS_STATUS: s_nxt.dout = status;
			ASA_RS_CMD: s_nxt.dout = s_r.cmd;
			ASA_RS_CTRL: s_nxt.dout = s_r.ctrl;
		endcase
		s_nxt.oe_n = ~(sel & b.phi2 & b.rw);

		if (wr) begin
			unique case (rs)
				ASA_RS_DATA: begin
					s_nxt.transmit_data = b.data;
					s_nxt.tx_reg_empty = 1'b0;
				end
				ASA_RS_STATUS: begin
					s_nxt.cmd[4:0] = 5'h00;
					s_nxt.overrun_flag = 1'b0;
				end
				ASA_RS_CMD: s_nxt.cmd = b.data;
				ASA_RS_CTRL: s_nxt.ctrl = b.data;
			endcase
		end
		if (rd && rs == ASA_RS_DATA) begin
			s_nxt.rx_reg_full = 1'b0;
			s_nxt.overrun_flag = 1'b0;
			s_nxt.fe = 1'b0;
			s_nxt.pe = 1'b0;
		end
		if (rd && rs == ASA_RS_STATUS) begin
			s_nxt.irq = 1'b0;
		end

		// baud generator counts crystal edges; divisor 1 means external clock
		div = ASA_BAUD_DIV[s_r.ctrl[3:0]];
		if (m.crystal_in && !s_r.xtal_d) begin
			if (s_r.baud_cnt >= div - 12'h001) begin
				s_nxt.baud_cnt = 12'h000;
				tick16 = 1'b1;
			end else begin
				s_nxt.baud_cnt = s_r.baud_cnt + 12'h001;
			end
		end
		s_nxt.rxc_o = (s_r.ctrl[3:0] == 4'h0) ? m.crystal_in : (s_r.baud_cnt < (div >> 1));
		s_nxt.rxc_oe_n = ~s_r.ctrl[ASA_CTRL_RCS];
		rx_tick = s_r.ctrl[ASA_CTRL_RCS] ? tick16 : (m.receive_clock_pin & ~s_r.rxc_d);

		// character format
		pme = s_r.cmd[ASA_CMD_PME];
		wl = 4'h8 - {2'h0, s_r.ctrl[ASA_CTRL_WL +: 2]};
		masked = s_r.transmit_data & (8'hFF >> s_r.ctrl[ASA_CTRL_WL +: 2]);
		half_stop = s_r.ctrl[ASA_CTRL_SBN] & (wl == 4'h5) & ~pme;
		two_stop = s_r.ctrl[ASA_CTRL_SBN] & ~half_stop & ~((wl == 4'h8) & pme);
		unique case (s_r.cmd[ASA_CMD_PMC +: 2])
			2'h0: par = ~^masked;
			2'h1: par = ^masked;
			2'h2: par = 1'b1;
			2'h3: par = 1'b0;
		endcase
		fr[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < wl) begin
				fr[i + 1] = s_r.transmit_data[i];
			end
		end
		if (pme) begin
			fr[wl + 4'h1] = par;
		end

		// interrupt enables
		rx_ie = s_r.cmd[ASA_CMD_DTR] & ~s_r.cmd[ASA_CMD_IRD];
		tx_ie = s_r.cmd[ASA_CMD_DTR] & (s_r.cmd[ASA_CMD_TIC +: 2] == 2'h1);
		if (rx_ie && (m.dsr_n != s_r.dsr_d || m.carrier_detect_n != s_r.dcd_d)) begin
			s_nxt.irq = 1'b1;
		end

		// transmitter
		tx_en = s_r.cmd[ASA_CMD_DTR] & (s_r.cmd[ASA_CMD_TIC +: 2] != 2'h0) & ~m.cts_n;
		unique case (s_r.tx_st)
			ASA_TX_IDLE: begin
				s_nxt.txd = 1'b1;
				if (s_r.cmd[ASA_CMD_REM] && s_r.cmd[ASA_CMD_TIC +: 2] == 2'h0) begin
					s_nxt.txd = m.rxd;
				end
				if (s_r.cmd[ASA_CMD_TIC +: 2] == 2'h3 && s_r.tx_reg_empty) begin
					s_nxt.txd = 1'b0;
				end
				if (tx_en && !s_r.tx_reg_empty) begin
					s_nxt.tx_sh = fr;
					s_nxt.tx_nbits = 4'h1 + wl + {3'h0, pme} + (two_stop ? 4'h2 : 4'h1);
					s_nxt.tx_bit = 4'h0;
					s_nxt.tx_tick = 5'h00;
					s_nxt.txd = fr[0];
					s_nxt.tx_reg_empty = 1'b1;
					s_nxt.tx_st = ASA_TX_RUN;
					if (tx_ie) begin
						s_nxt.irq = 1'b1;
					end
				end
			end
			ASA_TX_RUN: begin
				last = s_r.tx_bit == s_r.tx_nbits - 4'h1;
				len = (last && half_stop) ? ASA_TICKS_STOP15 : ASA_TICKS_BIT;
				if (!tx_en) begin
					s_nxt.txd = 1'b1;
					s_nxt.tx_st = ASA_TX_IDLE;
				end else if (tick16) begin
					if (s_r.tx_tick == len - 5'h01) begin
						s_nxt.tx_tick = 5'h00;
						if (last) begin
							s_nxt.tx_st = ASA_TX_IDLE;
						end else begin
							s_nxt.tx_bit = s_r.tx_bit + 4'h1;
							s_nxt.tx_sh = s_r.tx_sh >> 1;
							s_nxt.txd = s_r.tx_sh[1];
						end
					end else begin
						s_nxt.tx_tick = s_r.tx_tick + 5'h01;
					end
				end
			end
		endcase

		// receiver
		if (fifo_in_ready && s_r.rx_push) begin
			s_nxt.rx_push = 1'b0;
		end
		unique case (s_r.rx_st)
			ASA_RX_IDLE: begin
				if (rx_tick && !m.rxd && s_r.cmd[ASA_CMD_DTR]) begin
					s_nxt.rx_tick = 5'h00;
					s_nxt.rx_st = ASA_RX_START;
				end
			end
			ASA_RX_START: begin
				if (rx_tick) begin
					if (s_r.rx_tick == ASA_TICKS_HALF - 5'h01) begin
						s_nxt.rx_tick = 5'h00;
						s_nxt.rx_bit = 4'h0;
						s_nxt.rx_sh = 8'h00;
						s_nxt.rx_st = m.rxd ? ASA_RX_IDLE : ASA_RX_BITS;
					end else begin
						s_nxt.rx_tick = s_r.rx_tick + 5'h01;
					end
				end
			end
			ASA_RX_BITS: begin
				if (rx_tick) begin
					if (s_r.rx_tick == ASA_TICKS_BIT - 5'h01) begin
						s_nxt.rx_tick = 5'h00;
						s_nxt.rx_bit = s_r.rx_bit + 4'h1;
						if (s_r.rx_bit < wl) begin
							s_nxt.rx_sh[s_r.rx_bit[2:0]] = m.rxd;
						end else if (pme && s_r.rx_bit == wl) begin
							s_nxt.rx_par = m.rxd;
						end else begin
							s_nxt.rx_st = ASA_RX_IDLE;
							if (fifo_in_ready && !s_r.rx_push) begin
								s_nxt.rx_push = 1'b1;
								s_nxt.rx_word = {~m.rxd,
									pme & ~s_r.cmd[ASA_CMD_PMC + 1] &
									(s_r.rx_par != (s_r.cmd[ASA_CMD_PMC] ? ^s_r.rx_sh : ~^s_r.rx_sh)),
									s_r.rx_sh};
							end else begin
								s_nxt.overrun_flag = 1'b1;
							end
						end
					end else begin
						s_nxt.rx_tick = s_r.rx_tick + 5'h01;
					end
				end
			end
			default: s_nxt.rx_st = ASA_RX_IDLE;
		endcase

		// move the oldest buffered character into the receive register
		if (fifo_out_valid && !s_r.rx_reg_full) begin
			s_nxt.receive_data = fifo_out_data[7:0];
			s_nxt.pe = fifo_out_data[8];
			s_nxt.fe = fifo_out_data[9];
			s_nxt.rx_reg_full = 1'b1;
			if (rx_ie) begin
				s_nxt.irq = 1'b1;
			end
		end

		// hardware reset pin, already synchronised
		if (!s_r.hrst_s2) begin
			s_nxt.cmd = ASA_CMD_RST;
			s_nxt.ctrl = ASA_CTRL_RST;
			s_nxt.tx_reg_empty = 1'b1;
			s_nxt.rx_reg_full = 1'b0;
			s_nxt.overrun_flag = 1'b0;
			s_nxt.fe = 1'b0;
			s_nxt.pe = 1'b0;
			s_nxt.irq = 1'b0;
			s_nxt.rx_push = 1'b0;
			s_nxt.tx_st = ASA_TX_IDLE;
			s_nxt.rx_st = ASA_RX_IDLE;
			s_nxt.txd = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.tx_reg_empty <= 1'b1;
			s_r.txd <= 1'b1;
			s_r.oe_n <= 1'b1;
			s_r.rxc_oe_n <= 1'b1;
			s_r.tx_st <= ASA_TX_IDLE;
			s_r.rx_st <= ASA_RX_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign data_out = s_r.dout;
	assign data_oe_n = s_r.oe_n;
	assign irq_out = 1'b0;
	assign irq_oe_n = ~s_r.irq;
	assign txd = s_r.txd;
	assign rts_n = (s_r.cmd[ASA_CMD_TIC +: 2] == 2'h0) & ~s_r.cmd[ASA_CMD_REM];
	assign dtr_n = ~s_r.cmd[ASA_CMD_DTR];
	assign receive_clock_out = s_r.rxc_o;
	assign receive_clock_oe_n = s_r.rxc_oe_n;
	assign crystal_out = s_r.xo;
endmodule

//--- testbench/asa_props.sv
`timescale 1ns/10ps
module asa_props (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// processor side
	input wire logic hw_reset_n,
	input wire asa_pkg::asa_bus_in_s bus_in,
	input wire logic data_oe_n,
	input wire logic irq_out,
	input wire logic irq_oe_n,
	// modem side
	input wire asa_pkg::asa_modem_in_s modem_in,
	input wire logic txd,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic receive_clock_oe_n
);
	import asa_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// pins reach the output register three edges later
	sequence rd_seen;
		$past(bus_in.phi2, 3) && $past(bus_in.select_high, 3) && !$past(bus_in.select_low_n, 3) && $past(bus_in.rw, 3);
	endsequence
	sequence hw_held;
		!hw_reset_n [*8];
	endsequence
	sequence cts_held;
		modem_in.cts_n [*6];
	endsequence
	chk_oe_cause: assert property (!data_oe_n |-> rd_seen)
		else $error("data bus driven outside a selected read");
	chk_oe_drive: assert property (rd_seen |-> !data_oe_n)
		else $error("selected read not driven");
	chk_oe_release: assert property ($rose(data_oe_n) |-> !$past(bus_in.phi2, 3))
		else $error("data bus released while phase two high");
	chk_irq_drain: assert property (irq_out == 1'b0)
		else $error("interrupt line driven high");
	chk_hw_quiet: assert property (hw_held |-> irq_oe_n && dtr_n && rts_n && receive_clock_oe_n)
		else $error("outputs active during hardware reset");
	chk_cts_block: assert property (cts_held |-> txd)
		else $error("transmitting while clear to send high");
	chk_tx_gate: assert property ($fell(txd) |-> !dtr_n && !$past(modem_in.cts_n, 3))
		else $error("frame started while disabled");
	chk_off_idle: assert property (dtr_n [*3] |-> txd)
		else $error("line active while terminal not ready");
endmodule
bind asa_top asa_props chk_u (
	.clock(clock), .rst(rst), .hw_reset_n(hw_reset_n), .bus_in(bus_in), .data_oe_n(data_oe_n),
	.irq_out(irq_out), .irq_oe_n(irq_oe_n), .modem_in(modem_in), .txd(txd), .rts_n(rts_n),
	.dtr_n(dtr_n), .receive_clock_oe_n(receive_clock_oe_n)
);

//--- testbench/asa_modem.sv
`timescale 1ns/10ps
module asa_modem #(
	parameter int BIT_NS = 6400
) (
	// serial from the adapter
	input wire logic txd,
	// lines into the adapter
	output logic rxd,
	output logic cts_n,
	output logic dsr_n,
	output logic carrier_detect_n,
	output logic rx_clock
);
	logic run;
	logic [7:0] got;
	int nbits;
	int frames;
	// receiver clock at 16x, standing still outside our own frames
	initial begin
		rx_clock = 1'b0;
		forever #(BIT_NS / 32) rx_clock = run ? ~rx_clock : 1'b0;
	end
	initial begin
		rxd = 1'b1;
		run = 1'b0;
		cts_n = 1'b0;
		dsr_n = 1'b1;
		carrier_detect_n = 1'b1;
		nbits = 8;
		frames = 0;
		forever begin
			@(negedge txd);
			got = 8'h00;
			#(BIT_NS / 2);
			for (int i = 0; i < nbits; i++) begin
				#(BIT_NS);
				got[i] = txd;
			end
			#(BIT_NS);
			frames++;
		end
	end
	task automatic lines(input logic cts, input logic dsr, input logic dcd);
		cts_n = cts;
		dsr_n = dsr;
		carrier_detect_n = dcd;
	endtask
	task automatic send(input logic [7:0] d, input int n);
		run = 1'b1;
		#(BIT_NS);
		rxd = 1'b0;
		for (int i = 0; i < n; i++) begin
			#(BIT_NS);
			rxd = d[i];
		end
		#(BIT_NS);
		rxd = 1'b1;
		#(2 * BIT_NS);
		run = 1'b0;
	endtask
endmodule

//--- testbench/async_serial_adapter_bench.sv
`timescale 1ns/10ps
module async_serial_adapter_bench;
	import asa_pkg::*;
	typedef struct packed {
		logic [1:0] rs;
		logic [7:0] val;
	} asa_row_s;
	localparam asa_row_s ROWS [4] = '{'{ASA_RS_CMD, 8'hA5}, '{ASA_RS_CTRL, 8'h5A}, '{ASA_RS_CMD, 8'h0A},
		'{ASA_RS_CTRL, 8'h00}};
	string nm [4] = '{"data", "status", "command", "control"};
	logic clock, rst, hw_reset_n, xtal, data_oe_n, irq_out, irq_oe_n, txd, rts_n, dtr_n;
	logic receive_clock_out, receive_clock_oe_n, crystal_out, rxd, cts_n, dsr_n, dcd_n, rx_clock;
	logic [7:0] data_out, rd, cmd_m, ctrl_m;
	asa_bus_in_s bus_in;
	asa_modem_in_s modem_in;
	int errors, n_compared, cycles;
	// the receive clock wire is driven by whichever side has it enabled
	assign modem_in = {rxd, cts_n, dsr_n, dcd_n, receive_clock_oe_n ? rx_clock : receive_clock_out, xtal};
	asa_top dut_u (
		.clock(clock), .rst(rst), .hw_reset_n(hw_reset_n), .bus_in(bus_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n), .modem_in(modem_in), .txd(txd),
		.rts_n(rts_n), .dtr_n(dtr_n), .receive_clock_out(receive_clock_out),
		.receive_clock_oe_n(receive_clock_oe_n), .crystal_out(crystal_out)
	);
	asa_modem modem_u (
		.txd(txd), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .carrier_detect_n(dcd_n), .rx_clock(rx_clock)
	);
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// external transmit clock, one 16x tick per rising edge
	initial begin
		xtal = 1'b0;
		forever #200 xtal = ~xtal;
	end
	task automatic complete_run();
		if (errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// floating bus reads back as Z
	task automatic acc(input logic [1:0] rs, input logic rw, input logic [7:0] wd);
		@(negedge clock);
		bus_in = '{1'b1, 1'b0, rs[1], rs[0], rw, 1'b1, wd};
		repeat (4) @(negedge clock);
		rd = data_oe_n ? 8'hZZ : data_out;
		bus_in.phi2 = 1'b0;
		repeat (4) @(negedge clock);
		bus_in.select_high = 1'b0;
	endtask
	task automatic wr(input logic [1:0] rs, input logic [7:0] d);
		acc(rs, 1'b0, d);
	endtask
	task automatic rdc(input logic [1:0] rs, input logic [7:0] exp);
		acc(rs, 1'b1, 8'h00);
		chk(nm[rs], exp, rd);
	endtask
	task automatic hw_pulse(input logic [7:0] st);
		@(negedge clock);
		hw_reset_n = 1'b0;
		repeat (10) @(negedge clock);
		hw_reset_n = 1'b1;
		repeat (4) @(negedge clock);
		rdc(ASA_RS_CMD, ASA_CMD_RST);
		rdc(ASA_RS_CTRL, ASA_CTRL_RST);
		rdc(ASA_RS_STATUS, st);
		chk("rts_n", 8'h01, {7'h00, rts_n});
	endtask
	task automatic tx_one(input int n, input logic [7:0] d, input logic [7:0] exp, input logic blk);
		int f;
		modem_u.nbits = n;
		f = modem_u.frames;
		modem_u.lines(blk, 1'b1, 1'b1);
		wr(ASA_RS_DATA, d);
		if (blk) begin
			repeat (800) @(negedge clock);
			chk("frames", 8'(f), 8'(modem_u.frames));
			modem_u.lines(1'b0, 1'b1, 1'b1);
		end
		for (int i = 0; i < 1000 && modem_u.frames == f; i++)
			@(negedge clock);
		chk("tx data", exp, modem_u.got);
	endtask
	initial begin
		rst = 1'b1;
		hw_reset_n = 1'b0;
		bus_in = '0;
		errors = 0;
		n_compared = 0;
		cycles = 0;
		cmd_m = 8'h00;
		ctrl_m = 8'h00;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		hw_pulse(8'h70);
		foreach (ROWS[i]) begin
			wr(ROWS[i].rs, ROWS[i].val);
			cmd_m = ROWS[i].rs == ASA_RS_CMD ? ROWS[i].val : cmd_m;
			ctrl_m = ROWS[i].rs == ASA_RS_CTRL ? ROWS[i].val : ctrl_m;
			rdc(ROWS[i].rs, ROWS[i].val);
			chk("dtr_n", {7'h00, ~cmd_m[0]}, {7'h00, dtr_n});
			chk("rxc_oe_n", {7'h00, ~ctrl_m[4]}, {7'h00, receive_clock_oe_n});
		end
		wr(ASA_RS_CTRL, 8'h00);
		wr(ASA_RS_CMD, 8'h0B);
		tx_one(8, 8'h96, 8'h96, 1'b0);
		tx_one(8, 8'h3C, 8'h3C, 1'b1);
		wr(ASA_RS_CTRL, 8'h60);
		tx_one(5, 8'hF3, 8'h13, 1'b0);
		modem_u.lines(1'b0, 1'b0, 1'b0);
		wr(ASA_RS_CTRL, 8'h00);
		wr(ASA_RS_CMD, 8'h09);
		rdc(ASA_RS_STATUS, 8'h10);
		modem_u.send(8'h5C, 8);
		repeat (20) @(negedge clock);
		chk("irq_oe_n", 8'h00, {7'h00, irq_oe_n});
		rdc(ASA_RS_STATUS, 8'h98);
		rdc(ASA_RS_STATUS, 8'h18);
		rdc(ASA_RS_DATA, 8'h5C);
		rdc(ASA_RS_STATUS, 8'h10);
		wr(ASA_RS_CTRL, 8'h60);
		modem_u.send(8'h1B, 5);
		repeat (20) @(negedge clock);
		rdc(ASA_RS_DATA, 8'h1B);
		hw_pulse(8'h10);
		// two stop bits, and more characters than the receive path holds
		wr(ASA_RS_CTRL, 8'h80);
		wr(ASA_RS_CMD, 8'hC9);
		for (int i = 0; i < 18; i++)
			modem_u.send(8'h30 + 8'(i), 8);
		repeat (20) @(negedge clock);
		rdc(ASA_RS_STATUS, 8'h9C);
		wr(ASA_RS_STATUS, 8'hFF);
		rdc(ASA_RS_CMD, 8'hC0);
		rdc(ASA_RS_CTRL, 8'h80);
		rdc(ASA_RS_STATUS, 8'h18);
		rdc(ASA_RS_DATA, 8'h30);
		// break level on an idle, empty transmitter
		wr(ASA_RS_CMD, 8'h0D);
		repeat (10) @(negedge clock);
		chk("break txd", 8'h00, {7'h00, txd});
		chk("rts_n", 8'h00, {7'h00, rts_n});
		complete_run();
	end
endmodule
